// *** dest_reg_file.sv ***
// Purpose: Register file model standing on the far side of the write-back port.
// Assumes: At most one write per cycle, synchronous to clk_i.
// Notes: Contents start at zero, so a lost or extra write shows up as a wrong value.
module dest_reg_file (
    input wire logic clk_i, // Core clock.
    input wire logic rst_b_i, // Synchronous reset, active low.
    input wire fcvt_pkg::wb_t wb_i, // Write-back from the unit.
    input wire logic [6:0] rd_idx_i, // Register to look at.
    output logic [31:0] rd_data_o // Its contents.
);
    timeunit 1ns;
    timeprecision 1ps;
    import fcvt_pkg::*;

    logic [31:0] regs_q [128]; // Architectural registers.

    // Only reset or a write-back pulse may change a register; nothing else touches it.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < 128; i++) begin
                regs_q[i] <= 32'h0;
            end
        end else if (wb_i.valid) begin
            regs_q[wb_i.dest] <= wb_i.data;
        end
    end

    // The read side is combinational so the bench sees a write in the same cycle that it lands.
    assign rd_data_o = regs_q[rd_idx_i];
endmodule : dest_reg_file

// *** fcvt_pkg.sv ***
// Purpose: Shared constants and carrier types for the float-to-integer convert unit.
// Assumes: Single clock, synchronous active-low reset, 32-bit data path.
// Notes: Flag layout follows the status word exception bits.
package fcvt_pkg;
    // Operation codes and the issue slots that may carry them.
    localparam logic [7:0] OPC_ROUND_CONV = 8'h79; // Convert, status-word rounding.
    localparam logic [7:0] OPC_TRUNC_CONV = 8'h15; // Convert, toward zero.
    localparam logic [7:0] OPC_ROUND_FLAGS = 8'h7A; // Flags of the rounding convert.
    localparam logic [2:0] SLOT_A = 3'h1; // First legal slot.
    localparam logic [2:0] SLOT_B = 3'h4; // Second legal slot.
    // Exception flag vector layout.
    localparam int FLAG_W = 6; // Width of the exception field.
    localparam int INX_BIT = 1; // Inexact position.
    localparam int INV_BIT = 4; // Invalid position.
    localparam int IFZ_BIT = 5; // Flush-to-zero position.
    // Rounding modes held in the status word.
    localparam logic [1:0] RM_NEAREST = 2'h0; // Nearest, ties to even.
    localparam logic [1:0] RM_POS = 2'h1; // Toward plus infinity.
    localparam logic [1:0] RM_NEG = 2'h2; // Toward minus infinity.
    localparam logic [1:0] RM_ZERO = 2'h3; // Toward zero.
    // Register map of the plain software port.
    localparam logic [7:0] ADDR_FLAGS = 8'h00; // Sticky exception flags, write one to clear.
    localparam logic [7:0] ADDR_MASK = 8'h04; // Interrupt mask.
    localparam logic [7:0] ADDR_MODE = 8'h08; // Rounding mode.
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h00; // Flags after reset.
    localparam logic [FLAG_W-1:0] MASK_RESET = 6'h00; // Mask after reset.
    localparam logic [1:0] MODE_RESET = RM_NEAREST; // Mode after reset.
    // Single-precision field constants.
    localparam logic [7:0] EXP_MAX = 8'hFF; // Infinity or NaN.
    localparam logic [7:0] EXP_INT = 8'h96; // Exponent where the unit bit sits at bit 0.
    localparam logic [7:0] EXP_OVF = 8'h9E; // Magnitude at least two to the 31.
    localparam logic [7:0] EXP_HALF = 8'h7E; // Below this the value is under one half.
    localparam logic [31:0] INT_MAX = 32'h7FFFFFFF; // Positive saturation.
    localparam logic [31:0] INT_MIN = 32'h80000000; // Negative saturation.
    localparam int LATENCY = 3; // Issue to write-back, in cycles.

    typedef struct packed {
        logic valid; // Operation issued this cycle.
        logic [7:0] opcode; // Operation code.
        logic [2:0] slot; // Issue slot number.
        logic [31:0] operand; // Source operand bits.
        logic guard_used; // A guard register is present.
        logic [31:0] guard; // Guard register value.
        logic [6:0] dest; // Destination register index.
    } issue_t;

    typedef struct packed {
        logic valid; // Destination write this cycle.
        logic [6:0] dest; // Destination register index.
        logic [31:0] data; // Value to write.
    } wb_t;

    typedef struct packed {
        logic [31:0] data; // Integer result.
        logic [FLAG_W-1:0] flags; // Exceptions raised.
    } conv_t;

    typedef struct packed {
        logic valid; // Stage holds an operation.
        logic [7:0] opcode; // Operation code.
        logic en; // Guard allows the write.
        logic [6:0] dest; // Destination index.
        logic [31:0] operand; // Source operand.
        logic [1:0] mode; // Rounding mode in force.
    } stage1_t;

    typedef struct packed {
        logic valid; // Stage holds an operation.
        logic conv; // Operation is a converting one.
        logic en; // Guard allows the write.
        logic [6:0] dest; // Destination index.
        logic [31:0] data; // Value for the destination.
        logic [FLAG_W-1:0] flags; // Exceptions of the conversion.
    } stage2_t;

    typedef struct packed {
        stage1_t s1; // Operand stage.
        stage2_t s2; // Result stage.
        wb_t wb; // Write-back stage.
        logic [FLAG_W-1:0] flags; // Sticky exception flags.
        logic [FLAG_W-1:0] mask; // Interrupt mask.
        logic [1:0] mode; // Rounding mode.
        logic [31:0] rdata; // Read data.
    } state_t;
endpackage : fcvt_pkg

// *** float_to_int_convert_unit.sv ***
// Purpose: Float-to-signed-integer convert slice of the floating-point ALU.
// Assumes: Issue and register port signals are synchronous to clk_i.
// Notes: Three-stage pipeline; status flags and write-back change on one edge.
// Contract
// [RULE1] Rounding convert uses status-word rounding mode.
// [RULE2] Truncating convert always rounds toward zero.
// [RULE3] Flags operation returns the rounding-convert exceptions.
// [RULE4] Flags operation never touches status flags.
// [RULE5] Flags operation flushes denormals, sets flush bit.
// [RULE6] Converts flush denormals and raise flush flag.
// [RULE7] Convert exceptions set matching status flags.
// [RULE8] Status flags sticky; only explicit write clears.
// [RULE9] Flag update coincides with destination write.
// [RULE10] Concurrent updates OR into previous flags.
// [RULE11] False guard blocks destination and flags.
// [RULE12] False guard blocks flags operation destination.
// [RULE13] Three-cycle latency, one operand, slots 1, 4.
// [RULE14] Saturate out-of-range, NaN gives zero, invalid.
// [RULE15] Inexact bit 1, invalid bit 4, flush bit 5.
//
// Strobed register access and the placing of the registers were chosen for this implementation.

module float_to_int_convert_unit (
    input wire logic clk_i, // Core clock.
    input wire logic rst_b_i, // Synchronous reset, active low.
    input wire fcvt_pkg::issue_t issue_i, // Issue port.
    input wire logic [fcvt_pkg::FLAG_W-1:0] other_flags_i, // Updates from other units.
    input wire logic [7:0] reg_addr_i, // Register address.
    input wire logic [31:0] reg_wdata_i, // Register write data.
    input wire logic reg_wr_i, // Register write strobe.
    input wire logic reg_rd_i, // Register read strobe.
    output logic [31:0] reg_rdata_o, // Read data, cycle after the strobe.
    output fcvt_pkg::wb_t wb_o, // Destination write-back.
    output logic [fcvt_pkg::FLAG_W-1:0] psw_flags_o, // Status word exception flags.
    output logic irq_o // Unmasked flag set.
);
    import fcvt_pkg::*;

    state_t s_q; // Whole registered state.
    state_t s_d; // Its next value.
    logic accept; // Issue is a legal operation of this unit.
    logic enable; // Guard lets the issue write.
    logic [FLAG_W-1:0] clr; // Flags cleared by software this cycle.
    logic [FLAG_W-1:0] sets; // Flags raised this cycle.
    conv_t cv; // Conversion of the operand stage.

    // Converts one operand; the mode picks the rounding of the discarded fraction.
    function automatic conv_t fcvt(input logic [31:0] a, input logic [1:0] rm);
        logic sgn;
        logic [7:0] ex;
        logic [22:0] fr;
        logic [63:0] ext;
        logic [31:0] ip;
        logic [31:0] fp;
        logic up;
        logic [32:0] mag;
        conv_t r;

        // Split the operand into its fields and clear every working value.
        sgn = a[31];
        ex = a[30:23];
        fr = a[22:0];
        r = '0;
        ext = '0;
        ip = '0;
        fp = '0;
        up = 1'b0;
        mag = '0;

        if (ex == 8'h00) begin
            // Zero or denormal: result zero, a denormal raises flush-to-zero.
            r.flags[IFZ_BIT] = |fr; // [RULE5] [RULE6]
        end else if (ex == EXP_MAX) begin
            // Infinity saturates, NaN yields zero, both invalid.
            r.flags[INV_BIT] = 1'b1; // [RULE14]
            if (fr == 23'h000000) begin
                r.data = sgn ? INT_MIN : INT_MAX;
            end
        end else if (ex >= EXP_OVF) begin
            // Only exactly minus two to the 31 fits here.
            if (sgn && ex == EXP_OVF && fr == 23'h000000) begin
                r.data = INT_MIN;
            end else begin
                r.flags[INV_BIT] = 1'b1; // [RULE14]
                r.data = sgn ? INT_MIN : INT_MAX;
            end
        end else begin
            // A normal value that fits the integer range before rounding.
            if (ex < EXP_HALF) begin
                // Under one half: nothing survives but a sticky remainder.
                fp = 32'h00000001;
            end else begin
                // The hidden one goes in so the binary point sits between the two halves.
                ext = {8'h00, 1'b1, fr, 32'h00000000};
                // Large exponents move the unit bit up, small ones push it into the fraction.
                if (ex >= EXP_INT) begin
                    ext = ext << (ex - EXP_INT);
                end else begin
                    ext = ext >> (EXP_INT - ex);
                end
                ip = ext[63:32];
                fp = ext[31:0];
            end

            // The rounding mode, with the discarded fraction and the sign, decides whether the magnitude steps up by one.
            unique case (rm)
                RM_NEAREST: up = fp[31] && ((|fp[30:0]) || ip[0]); // [RULE1]
                RM_POS: up = (|fp) && !sgn; // [RULE1]
                RM_NEG: up = (|fp) && sgn; // [RULE1]
                RM_ZERO: up = 1'b0; // [RULE2]
            endcase
            // One spare bit keeps a carry out of the top visible.
            mag = {1'b0, ip} + {32'h00000000, up};
            // Rounding up can reach two to the 31, legal only when negative.
            if (mag[31] && !sgn) begin
                r.flags[INV_BIT] = 1'b1; // [RULE14]
                r.data = INT_MAX;
            end else begin
                r.flags[INX_BIT] = |fp; // [RULE15]
                r.data = sgn ? (~mag[31:0] + 32'h00000001) : mag[31:0];
            end
        end

        return r;
    endfunction : fcvt

    // Decode the issue port; other opcodes or slots belong to other units.
    always_comb begin
        accept = issue_i.valid && (issue_i.slot == SLOT_A || issue_i.slot == SLOT_B) && // [RULE13]
            (issue_i.opcode == OPC_ROUND_CONV || issue_i.opcode == OPC_TRUNC_CONV ||
             issue_i.opcode == OPC_ROUND_FLAGS);
        // Without a guard register the operation always writes.
        enable = !issue_i.guard_used || issue_i.guard[0]; // [RULE11] [RULE12]
    end

    // Next-state logic for the pipeline, the flags and the register port.
    always_comb begin
        s_d = s_q;
        cv = fcvt(s_q.s1.operand, s_q.s1.mode);

        // Operand stage: the truncating op forces round toward zero.
        s_d.s1.valid = accept;
        s_d.s1.opcode = issue_i.opcode;
        s_d.s1.en = enable;
        s_d.s1.dest = issue_i.dest;
        s_d.s1.operand = issue_i.operand;
        s_d.s1.mode = (issue_i.opcode == OPC_TRUNC_CONV) ? RM_ZERO : s_q.mode; // [RULE1] [RULE2]

        // Result stage: the flags op returns the vector instead of the integer.
        s_d.s2.valid = s_q.s1.valid;
        s_d.s2.conv = s_q.s1.opcode != OPC_ROUND_FLAGS; // [RULE4]
        s_d.s2.en = s_q.s1.en;
        s_d.s2.dest = s_q.s1.dest;
        s_d.s2.flags = cv.flags;
        if (s_q.s1.opcode == OPC_ROUND_FLAGS) begin
            s_d.s2.data = {{(32 - FLAG_W){1'b0}}, cv.flags}; // [RULE3] [RULE15]
        end else begin
            s_d.s2.data = cv.data;
        end

        // Write-back stage: a false guard suppresses the write entirely.
        s_d.wb.valid = s_q.s2.valid && s_q.s2.en; // [RULE11] [RULE12] [RULE13]
        if (s_q.s2.valid && s_q.s2.en) begin
            s_d.wb.dest = s_q.s2.dest;
            s_d.wb.data = s_q.s2.data;
        end

        // Flag update lands on the same edge as the write-back above.
        clr = '0;
        if (reg_wr_i && reg_addr_i == ADDR_FLAGS) begin
            clr = reg_wdata_i[FLAG_W-1:0]; // [RULE8]
        end
        // Other units report every cycle; their updates merge whatever this unit does.
        sets = other_flags_i; // [RULE10]
        // The flags op only reports its vector, so it never feeds the status word.
        if (s_q.s2.valid && s_q.s2.en && s_q.s2.conv) begin
            sets = sets | s_q.s2.flags; // [RULE7] [RULE9] [RULE11]
        end

        // A set in the clearing cycle wins, so no event is lost.
        s_d.flags = (s_q.flags & ~clr) | sets; // [RULE8] [RULE10]

        // Mask and mode writes.
        if (reg_wr_i && reg_addr_i == ADDR_MASK) begin
            s_d.mask = reg_wdata_i[FLAG_W-1:0];
        end
        if (reg_wr_i && reg_addr_i == ADDR_MODE) begin
            s_d.mode = reg_wdata_i[1:0];
        end

        // Read data stand for one cycle only; unmapped reads give zero.
        s_d.rdata = '0;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADDR_FLAGS: s_d.rdata = {{(32 - FLAG_W){1'b0}}, s_q.flags};
                ADDR_MASK: s_d.rdata = {{(32 - FLAG_W){1'b0}}, s_q.mask};
                ADDR_MODE: s_d.rdata = {30'h00000000, s_q.mode};
                default: s_d.rdata = '0;
            endcase
        end
    end

    // State register; reset empties the pipe and clears the flags.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
            // Named reset values are restated so a changed constant still takes effect.
            s_q.flags <= FLAGS_RESET;
            s_q.mask <= MASK_RESET;
            s_q.mode <= MODE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from the state register.
    assign wb_o = s_q.wb;
    assign psw_flags_o = s_q.flags;
    assign reg_rdata_o = s_q.rdata;
    // A level interrupt: it falls only when the flag is cleared or masked off.
    assign irq_o = |(s_q.flags & s_q.mask);

    // Write-back arrives exactly three cycles after an enabled issue.
    a_latency_three: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE13]
        accept && enable |-> ##3 wb_o.valid)
        else $error("write-back missing three cycles after issue");

    // A false guard produces no write-back.
    a_guard_blocks_wb: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE11] [RULE12]
        accept && !enable |-> ##3 !wb_o.valid)
        else $error("write-back despite false guard");

    // Flags op with no other source adds nothing; only a clearing write may drop a flag.
    a_flags_op_kept: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE4]
        s_q.s2.valid && !s_q.s2.conv && other_flags_i == '0 |=>
        psw_flags_o == ($past(psw_flags_o) & ~$past(clr)))
        else $error("flags operation changed status flags");

    // Without a clearing write no flag ever falls.
    a_sticky_flags: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE8]
        !(reg_wr_i && reg_addr_i == ADDR_FLAGS) |=> (psw_flags_o & $past(psw_flags_o)) == $past(psw_flags_o))
        else $error("sticky flag dropped");

    // Updates from other units always land.
    a_or_merge: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE10]
        1'b1 |=> (psw_flags_o & $past(other_flags_i)) == $past(other_flags_i))
        else $error("concurrent flag update lost");

    // Convert flags appear together with the destination write.
    a_flags_with_wb: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE7] [RULE9]
        s_q.s2.valid && s_q.s2.en && s_q.s2.conv |=>
        wb_o.valid && (psw_flags_o & $past(s_q.s2.flags)) == $past(s_q.s2.flags))
        else $error("convert flags not set with write-back");

    // Truncation of 2.57 gives 2.
    a_trunc_value: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE2]
        accept && enable && issue_i.opcode == OPC_TRUNC_CONV && issue_i.operand == 32'h40247AE1 |->
        ##3 wb_o.data == 32'h00000002)
        else $error("truncating convert wrong");

    // Nearest rounding of -1.51 gives -2.
    a_round_value: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE1]
        accept && enable && issue_i.opcode == OPC_ROUND_CONV && s_q.mode == RM_NEAREST &&
        !(reg_wr_i && reg_addr_i == ADDR_MODE) && issue_i.operand == 32'hBFC147AE |-> ##3 wb_o.data == 32'hFFFFFFFE)
        else $error("rounding convert wrong");

    // A denormal flags vector is just the flush bit.
    a_denorm_vector: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE3] [RULE5] [RULE15]
        accept && enable && issue_i.opcode == OPC_ROUND_FLAGS && issue_i.operand == 32'h00400000 |->
        ##3 wb_o.data == 32'h00000020)
        else $error("flag vector for denormal wrong");

    // A denormal convert writes zero and raises the flush flag.
    a_denorm_conv: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE6]
        accept && enable && issue_i.opcode == OPC_TRUNC_CONV && issue_i.operand == 32'h00400000 |->
        ##3 wb_o.data == 32'h00000000 && psw_flags_o[IFZ_BIT])
        else $error("denormal not flushed");

    // A NaN converts to zero with invalid raised.
    a_nan_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE14]
        accept && enable && issue_i.opcode != OPC_ROUND_FLAGS && issue_i.operand == 32'hFFBFFFFF |->
        ##3 wb_o.data == 32'h00000000 && psw_flags_o[INV_BIT])
        else $error("NaN convert wrong");

    // An issue held back by a false guard.
    c_guarded_conv: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        accept && issue_i.guard_used && !enable);

    // A flags operation reaching write-back.
    c_flags_op: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        accept && issue_i.opcode == OPC_ROUND_FLAGS ##3 wb_o.valid);

    // A flag raised in the same cycle as a clearing write.
    c_set_and_clear: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        reg_wr_i && reg_addr_i == ADDR_FLAGS && sets != '0);

    // A denormal convert arriving with the flush flag.
    c_denorm_flush: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        s_q.s2.valid && s_q.s2.en && s_q.s2.conv && s_q.s2.flags[IFZ_BIT] ##1 wb_o.valid);

    // Two enabled operations issued on consecutive cycles.
    c_back_to_back: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        accept && enable ##1 accept && enable);
endmodule : float_to_int_convert_unit

// *** float_to_int_convert_unit_tb.sv ***
// Purpose: Self-checking bench for the float-to-integer convert unit.
// Assumes: Inputs change by non-blocking assignment just after a rising edge.
// Notes: Expected results are hand-worked single-precision cases held in a table.
module float_to_int_convert_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fcvt_pkg::*;

    // One table row: opcode, rounding mode, operand, destination value, raised flags.
    typedef struct packed {
        logic [7:0] op;
        logic [1:0] md;
        logic [31:0] a;
        logic [31:0] d;
        logic [5:0] f;
    } row_t;
    localparam logic [7:0] RC = OPC_ROUND_CONV; // Short aliases keep the table readable.
    localparam logic [7:0] TC = OPC_TRUNC_CONV;
    localparam logic [7:0] FL = OPC_ROUND_FLAGS;
    localparam int N_ROWS = 25; // Modes: 0 nearest, 1 up, 2 down, 3 toward zero.
    localparam row_t TBL [N_ROWS] = '{
        '{RC, 2'h0, 32'h40400000, 32'h00000003, 6'h00}, '{RC, 2'h0, 32'h40247AE1, 32'h00000003, 6'h02},
        '{RC, 2'h0, 32'hFF4FFFFF, 32'h80000000, 6'h10}, '{RC, 2'h0, 32'h7F800000, 32'h7FFFFFFF, 6'h10},
        '{RC, 2'h0, 32'hBFC147AE, 32'hFFFFFFFE, 6'h02}, '{RC, 2'h0, 32'h00400000, 32'h00000000, 6'h20},
        '{RC, 2'h0, 32'hFFFFFFFF, 32'h00000000, 6'h10}, '{RC, 2'h0, 32'hFFBFFFFF, 32'h00000000, 6'h10},
        '{RC, 2'h1, 32'h40247AE1, 32'h00000003, 6'h02}, '{RC, 2'h2, 32'h40247AE1, 32'h00000002, 6'h02},
        '{RC, 2'h3, 32'h40247AE1, 32'h00000002, 6'h02}, '{RC, 2'h1, 32'hBFC147AE, 32'hFFFFFFFF, 6'h02},
        '{RC, 2'h2, 32'hBFC147AE, 32'hFFFFFFFE, 6'h02}, '{RC, 2'h0, 32'hCF000000, 32'h80000000, 6'h00},
        '{RC, 2'h1, 32'h3E800000, 32'h00000001, 6'h02}, '{RC, 2'h0, 32'h3E800000, 32'h00000000, 6'h02},
        '{TC, 2'h1, 32'h40247AE1, 32'h00000002, 6'h02}, '{TC, 2'h2, 32'hBFC147AE, 32'hFFFFFFFF, 6'h02},
        '{TC, 2'h0, 32'h7F800000, 32'h7FFFFFFF, 6'h10}, '{TC, 2'h0, 32'h00400000, 32'h00000000, 6'h20},
        '{FL, 2'h0, 32'h40247AE1, 32'h00000002, 6'h02}, '{FL, 2'h0, 32'hFF4FFFFF, 32'h00000010, 6'h10},
        '{FL, 2'h0, 32'h00400000, 32'h00000020, 6'h20}, '{FL, 2'h1, 32'hBFC147AE, 32'h00000002, 6'h02},
        '{FL, 2'h0, 32'h40400000, 32'h00000000, 6'h00}};

    logic clk_i = 1'b0; // Core clock.
    logic rst_b_i = 1'b0; // Reset, active low.
    issue_t issue_i = '0; // Issue port.
    logic [5:0] other_flags_i = '0; // Flag updates from other units.
    logic [7:0] reg_addr_i = '0; // Register port.
    logic [31:0] reg_wdata_i = '0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o; // Design outputs.
    wb_t wb_o;
    logic [5:0] psw_flags_o;
    logic irq_o;
    logic [6:0] rf_idx = '0; // Register file probe.
    logic [31:0] rf_data;
    int error_cnt = 0; // Mismatches seen.
    int n_compared = 0; // Comparisons made.
    int cyc = 0; // Cycles run, for the hang guard.

    // A 40 MHz clock.
    always #12.5 clk_i = ~clk_i;

    float_to_int_convert_unit float_to_int_convert_unit_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .issue_i(issue_i),
        .other_flags_i(other_flags_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .wb_o(wb_o), .psw_flags_o(psw_flags_o), .irq_o(irq_o));
    dest_reg_file dest_reg_file_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .wb_i(wb_o), .rd_idx_i(rf_idx),
        .rd_data_o(rf_data));

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("errors %0d, compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // Compares one value; a mismatch is reported at once.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One-cycle write; the extra delay lets the edge's updates land before the caller looks.
    task automatic reg_wr(input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= addr;
        reg_wdata_i <= data;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask : reg_wr

    // One-cycle read; data stand only in the following cycle.
    task automatic reg_rd(input logic [7:0] addr, input logic [31:0] exp);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= addr;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk("reg_rdata", exp, reg_rdata_o);
    endtask : reg_rd

    // Issues one operation and checks flags, write-back and register file around cycle three.
    task automatic run_op(input logic [7:0] op, input logic [2:0] sl, input logic [31:0] a, input logic gu,
        input logic g, input logic [6:0] dst, input logic [5:0] oth, input logic ev, input logic [31:0] ed,
        input logic [5:0] ep);
        logic [5:0] pre;
        pre = psw_flags_o;
        @(posedge clk_i);
        issue_i <= '{1'b1, op, sl, a, gu, (g ? 32'hFFFFFFF1 : 32'hFFFFFFFE), dst};
        rf_idx <= dst;
        @(posedge clk_i);
        issue_i.valid <= 1'b0;
        @(posedge clk_i);
        other_flags_i <= oth;
        #1 chk("flags_early", {26'h0, pre}, {26'h0, psw_flags_o});
        @(posedge clk_i);
        other_flags_i <= '0;
        #1 chk("wb_valid", {31'h0, ev}, {31'h0, wb_o.valid});
        if (ev) chk("wb_data", ed, wb_o.data);
        if (ev) chk("wb_dest", {25'h0, dst}, {25'h0, wb_o.dest});
        chk("psw_flags", {26'h0, ep}, {26'h0, psw_flags_o});
        @(posedge clk_i);
        #1 chk("reg_file", ed, rf_data);
    endtask : run_op

    // Hang guard well above the few hundred cycles the sequence needs.
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            end_sim();
        end
    end

    // Main sequence.
    initial begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1 chk("irq_rst", 32'h0, {31'h0, irq_o});
        chk("wb_rst", 32'h0, {31'h0, wb_o.valid});
        reg_rd(ADDR_FLAGS, 32'h0);
        reg_rd(ADDR_MASK, 32'h0);
        reg_rd(ADDR_MODE, 32'h0);
        reg_rd(8'h0C, 32'h0);
        reg_wr(ADDR_MODE, 32'h2);
        reg_wr(8'h0C, 32'h3);
        reg_rd(ADDR_MODE, 32'h2);
        for (int i = 0; i < N_ROWS; i++) begin
            reg_wr(ADDR_FLAGS, 32'h3F);
            reg_wr(ADDR_MODE, {30'h0, TBL[i].md});
            run_op(TBL[i].op, i[0] ? SLOT_B : SLOT_A, TBL[i].a, i[1], 1'b1, 7'(100 + i), 6'h00, 1'b1,
                TBL[i].d, (TBL[i].op == FL) ? 6'h00 : TBL[i].f);
        end
        // False guard, illegal slot and a foreign opcode leave destination 100 holding 3.
        run_op(RC, SLOT_A, 32'hFF4FFFFF, 1'b1, 1'b0, 7'd100, 6'h00, 1'b0, 32'h3, 6'h00);
        run_op(FL, SLOT_B, 32'hFF4FFFFF, 1'b1, 1'b0, 7'd100, 6'h00, 1'b0, 32'h3, 6'h00);
        run_op(RC, 3'h2, 32'h40247AE1, 1'b0, 1'b1, 7'd100, 6'h00, 1'b0, 32'h3, 6'h00);
        run_op(8'h81, SLOT_A, 32'h40247AE1, 1'b0, 1'b1, 7'd100, 6'h00, 1'b0, 32'h3, 6'h00);
        // Sticky flags merged with a concurrent update from another unit.
        reg_wr(ADDR_MODE, 32'h0);
        run_op(RC, SLOT_A, 32'h40247AE1, 1'b0, 1'b1, 7'd10, 6'h01, 1'b1, 32'h3, 6'h03);
        run_op(TC, SLOT_B, 32'h40400000, 1'b0, 1'b1, 7'd11, 6'h00, 1'b1, 32'h3, 6'h03);
        run_op(FL, SLOT_A, 32'hFF4FFFFF, 1'b0, 1'b1, 7'd12, 6'h00, 1'b1, 32'h10, 6'h03);
        reg_wr(ADDR_FLAGS, 32'h10);
        reg_rd(ADDR_FLAGS, 32'h03);
        // Interrupt raised through the mask, then cleared through the flags.
        reg_wr(ADDR_MASK, 32'h01);
        chk("irq_set", 32'h1, {31'h0, irq_o});
        reg_rd(ADDR_MASK, 32'h01);
        reg_wr(ADDR_FLAGS, 32'h01);
        chk("irq_clr", 32'h0, {31'h0, irq_o});
        chk("flags_w1c", 32'h02, {26'h0, psw_flags_o});
        reg_wr(ADDR_MASK, 32'h02);
        chk("irq_mask", 32'h1, {31'h0, irq_o});
        // Back-to-back issue: results leave on consecutive cycles.
        @(posedge clk_i);
        issue_i <= '{1'b1, RC, SLOT_A, 32'h40400000, 1'b0, 32'h0, 7'h10};
        @(posedge clk_i);
        issue_i <= '{1'b1, TC, SLOT_B, 32'hBFC147AE, 1'b0, 32'h0, 7'h11};
        @(posedge clk_i);
        issue_i.valid <= 1'b0;
        @(posedge clk_i);
        #1 chk("b2b_first", 32'h3, wb_o.data);
        @(posedge clk_i);
        #1 chk("b2b_second", 32'hFFFFFFFF, wb_o.data);
        chk("b2b_dest", 32'h11, {25'h0, wb_o.dest});
        end_sim();
    end
endmodule : float_to_int_convert_unit_tb
